// ---- hw/mlps_pkg.sv ----
package mlps_pkg;
  // Switch dimensions
  localparam int NPORT  = 10;
  localparam int PW     = 4;
  localparam int NGRP   = 5;
  localparam int GW     = 3;
  localparam int SPW    = 2;
  localparam int HW     = 8;
  localparam int CW     = 4;
  localparam int MAXACT = 8;
  localparam int DEPTH  = 16;
  localparam int MACW   = 48;
  localparam int IPW    = 32;
  localparam int L4W    = 16;
  localparam int DW     = 2 * PW + 1 + 2 * MACW + 2 * IPW + 2 * L4W + 2;

  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_MIR  = 8'h04;
  localparam logic [7:0] A_GRP  = 8'h08;
  localparam logic [7:0] A_GST  = 8'h20;
  localparam logic [7:0] A_LINK = 8'h40;
  localparam logic [7:0] A_STEP = 8'h04;

  // Control register fields
  localparam int C_EN   = 0;
  localparam int C_DST  = 4;
  localparam int C_HASH = 8;
  localparam int H_SMAC = 0;
  localparam int H_DMAC = 1;
  localparam int H_IP   = 2;
  localparam int H_L4   = 3;
  localparam logic [3:0] HASH_RST = 4'hd;

  // Mirror mode bits, two per port
  localparam int M_RX = 0;
  localparam int M_TX = 1;

  // Group config, group status and link status fields
  localparam int G_NEG = 16;
  localparam int G_SPD = 20;
  localparam int S_CNT = 16;
  localparam int S_UP  = 20;
  localparam int L_UP  = 0;
  localparam int L_FDX = 16;

  typedef enum logic [2:0] {
    R_CTRL,
    R_MIR,
    R_GRP,
    R_GST,
    R_LINK,
    R_NONE
  } mlps_reg_e;

  typedef struct packed {
    mlps_reg_e       kind;
    logic [GW-1:0]   idx;
  } mlps_dec_s;

  function automatic mlps_dec_s mlps_decode(input logic [7:0] a);
    mlps_dec_s  d;
    logic [7:0] off;
    d.kind = R_NONE;
    d.idx  = '0;
    off    = '0;
    if (a == A_CTRL)
      d.kind = R_CTRL;
    else if (a == A_MIR)
      d.kind = R_MIR;
    else if (a == A_LINK)
      d.kind = R_LINK;
    else if (a[1:0] == 2'h0 && a >= A_GRP && a < A_GRP + 8'(NGRP * 4))
    begin
      off    = a - A_GRP;
      d.kind = R_GRP;
      d.idx  = off[GW+1:2];
    end
    else if (a[1:0] == 2'h0 && a >= A_GST && a < A_GST + 8'(NGRP * 4))
    begin
      off    = a - A_GST;
      d.kind = R_GST;
      d.idx  = off[GW+1:2];
    end
    return d;
  endfunction
endpackage

// ---- hw/mlps_fifo.sv ----
`timescale 1ns/10ps
module mlps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,  // Clock
  input  wire logic             srst,     // Sync reset
  input  wire logic             ce,       // Clock enable
  input  wire logic             inValid,  // Word offered
  output logic                  inReady,  // Room for a word
  input  wire logic [WIDTH-1:0] inData,   // Word in
  output logic                  outValid, // Word available
  input  wire logic             outReady, // Word taken
  output logic      [WIDTH-1:0] outData   // Head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [AW:0]                 count;
  } mlps_fifo_s;

  mlps_fifo_s st;
  mlps_fifo_s next_st;
  logic       push;
  logic       pop;

  assign inReady  = st.count != (AW+1)'(DEPTH);
  assign outValid = st.count != '0;
  assign outData  = st.mem[st.rdPtr];
  assign push     = inValid && inReady && ce;
  assign pop      = outValid && outReady && ce;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr         = st.wrPtr + AW'(1);
    end
    if (pop)
      next_st.rdPtr = st.rdPtr + AW'(1);
    if (push && !pop)
      next_st.count = st.count + (AW+1)'(1);
    else if (pop && !push)
      next_st.count = st.count - (AW+1)'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st <= '0;
    else if (ce)
      st <= next_st;
  end
endmodule // mlps_fifo

// ---- hw/mlps_top.sv ----
// Functional notes
// - Copy selected frames to the mirror port
// - Mirror disabled means no copies at all
// - Rx-only mode copies received frames only
// - Tx-only mode copies transmitted frames only
// - Disabled mode copies nothing for that port
// - Both mode copies received and transmitted frames
// - Mirror port refuses transmit mirroring
// - Group acts as one logical port
// - Members need same speed, full duplex
// - A port joins at most one group
// - Group members never mirror source or destination
// - Static groups aggregate without negotiation
// - Up to 10 ports in 5 groups
// - Extra negotiated members wait in standby
// - One flow always uses one member
// - Hash uses MACs, IPv4 addresses, L4 ports
// - Per-input hash enables, destination MAC off
`timescale 1ns/10ps
module mlps_top (
  input  wire logic                  ref_clk,    // 40 MHz clock
  input  wire logic                  srst,       // Sync reset
  input  wire logic                  ce,         // Clock enable
  input  wire logic [7:0]            paddr,      // APB address
  input  wire logic                  psel,       // APB select
  input  wire logic                  penable,    // APB enable
  input  wire logic                  pwrite,     // APB write
  input  wire logic [31:0]           pwdata,     // APB write data
  output logic      [31:0]           prdata,     // APB read data
  output logic                       pready,     // APB ready
  output logic                       pslverr,    // APB error
  input  wire logic [mlps_pkg::NPORT-1:0] linkUp,     // Pin: link up
  input  wire logic [mlps_pkg::NPORT-1:0] fullDuplex, // Pin: duplex
  input  wire logic [mlps_pkg::NPORT-1:0][mlps_pkg::SPW-1:0]
                                     portSpeed,  // Pin: speed code
  input  wire logic                  inValid,    // Frame offered
  output logic                       inReady,    // Frame accepted
  input  wire logic [mlps_pkg::PW-1:0]   inSrcPort,  // Ingress port
  input  wire logic                  inDstIsGrp, // Dest is group
  input  wire logic [mlps_pkg::PW-1:0]   inDstId,    // Port or group
  input  wire logic [mlps_pkg::MACW-1:0] inSrcMac,   // Source MAC
  input  wire logic [mlps_pkg::MACW-1:0] inDstMac,   // Dest MAC
  input  wire logic [mlps_pkg::IPW-1:0]  inSrcIp,    // IPv4 source
  input  wire logic [mlps_pkg::IPW-1:0]  inDstIp,    // IPv4 dest
  input  wire logic [mlps_pkg::L4W-1:0]  inSrcL4,    // L4 source port
  input  wire logic [mlps_pkg::L4W-1:0]  inDstL4,    // L4 dest port
  input  wire logic                  inIsIpv4,   // IPv4 frame
  input  wire logic                  inIsL4,     // TCP or UDP
  output logic                       outValid,   // Decision valid
  input  wire logic                  outReady,   // Decision taken
  output logic      [mlps_pkg::PW-1:0]   outPort,    // Egress port
  output logic                       outDrop,    // No egress
  output logic                       outMirror,  // Make a copy
  output logic      [mlps_pkg::PW-1:0]   outMirPort  // Copy port
);
  import mlps_pkg::*;

  typedef struct packed {
    logic                          mirEn;
    logic [PW-1:0]                 mirDest;
    logic [3:0]                    hashEn;
    logic [NPORT-1:0][1:0]         mirMode;
    logic [NGRP-1:0][NPORT-1:0]    grpMem;
    logic [NGRP-1:0]               grpNeg;
    logic [NGRP-1:0][SPW-1:0]      grpSpd;
    logic [NPORT-1:0]              upM;
    logic [NPORT-1:0]              upS;
    logic [NPORT-1:0]              fdM;
    logic [NPORT-1:0]              fdS;
    logic [NPORT-1:0][SPW-1:0]     spM;
    logic [NPORT-1:0][SPW-1:0]     spS;
    logic                          apbArm;
    logic                          apbErr;
    logic [31:0]                   apbData;
    logic                          oValid;
    logic [PW-1:0]                 oPort;
    logic                          oDrop;
    logic                          oMir;
    logic [PW-1:0]                 oMirPort;
  } mlps_top_s;

  mlps_top_s                    st;
  mlps_top_s                    next_st;
  logic                         fValid;
  logic                         fReady;
  logic [DW-1:0]                fData;
  logic [PW-1:0]                fSrc;
  logic                         fIsGrp;
  logic [PW-1:0]                fDst;
  logic [MACW-1:0]              fSMac;
  logic [MACW-1:0]              fDMac;
  logic [IPW-1:0]               fSIp;
  logic [IPW-1:0]               fDIp;
  logic [L4W-1:0]               fSL4;
  logic [L4W-1:0]               fDL4;
  logic                         fIp4;
  logic                         fL4;
  logic [NGRP-1:0][NPORT-1:0]   elig;
  logic [NGRP-1:0][NPORT-1:0]   act;
  logic [NGRP-1:0][CW-1:0]      actCnt;
  logic [NPORT-1:0]             inGrp;
  logic [NPORT-1:0]             mirSrc;

  function automatic logic modeOf(
    input logic [NPORT-1:0][1:0] m,
    input logic [PW-1:0]         p,
    input int                    b
  );
    return (p < PW'(NPORT)) ? m[p][b] : 1'b0;
  endfunction

  function automatic logic bitOf(
    input logic [NPORT-1:0] m,
    input logic [PW-1:0]    p
  );
    return (p < PW'(NPORT)) ? m[p] : 1'b0;
  endfunction

  function automatic logic [CW-1:0] popc(input logic [NPORT-1:0] m);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < NPORT; i++)
      n = n + CW'(m[i]);
    return n;
  endfunction

  // Lowest-numbered members win; the rest stand by
  function automatic logic [NPORT-1:0] firstN(input logic [NPORT-1:0] m);
    logic [NPORT-1:0] r;
    int               n;
    r = '0;
    n = 0;
    for (int i = 0; i < NPORT; i++)
    begin
      if (m[i] && n < MAXACT)
      begin
        r[i] = 1'b1;
        n    = n + 1;
      end
    end
    return r;
  endfunction

  // Port number of the k-th set bit
  function automatic logic [PW-1:0] kth(
    input logic [NPORT-1:0] m,
    input logic [CW-1:0]    k
  );
    logic [PW-1:0] p;
    logic [CW-1:0] n;
    p = '0;
    n = '0;
    for (int i = 0; i < NPORT; i++)
    begin
      if (m[i])
      begin
        if (n == k)
          p = PW'(i);
        n = n + CW'(1);
      end
    end
    return p;
  endfunction

  function automatic logic [HW-1:0] fold(input logic [63:0] v);
    logic [HW-1:0] h;
    h = '0;
    for (int i = 0; i < 64 / HW; i++)
      h = h ^ v[i*HW +: HW];
    return h;
  endfunction

  mlps_fifo #(
    .WIDTH (DW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .ce       (ce),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   ({inSrcPort, inDstIsGrp, inDstId, inSrcMac, inDstMac,
                inSrcIp, inDstIp, inSrcL4, inDstL4, inIsIpv4, inIsL4}),
    .outValid (fValid),
    .outReady (fReady),
    .outData  (fData)
  );

  assign {fSrc, fIsGrp, fDst, fSMac, fDMac, fSIp, fDIp, fSL4, fDL4,
          fIp4, fL4} = fData;

  // Group membership and mirror source views
  always_comb
  begin
    inGrp  = '0;
    mirSrc = '0;
    for (int g = 0; g < NGRP; g++)
      inGrp = inGrp | st.grpMem[g];
    for (int i = 0; i < NPORT; i++)
      mirSrc[i] = st.mirMode[i] != 2'h0;
  end

  for (genvar g = 0; g < NGRP; g++)
  begin : gGrp
    logic [NPORT-1:0] spdOk;
    always_comb
    begin
      spdOk = '0;
      for (int i = 0; i < NPORT; i++)
        spdOk[i] = st.spS[i] == st.grpSpd[g];
    end
    assign elig[g]   = st.grpMem[g] & st.upS & st.fdS & spdOk;
    assign act[g]    = st.grpNeg[g] ? firstN(elig[g])
                                    : elig[g];
    assign actCnt[g] = popc(act[g]);
  end

  // Forwarding and mirror decision
  logic [HW-1:0]  hv;
  logic           grpOk;
  logic [GW-1:0]  gSel;
  logic [CW-1:0]  cnt;
  logic [HW-1:0]  pick;
  logic [PW-1:0]  egress;
  logic           drop;
  logic           rxSel;
  logic           txSel;

  always_comb
  begin
    hv = '0;
    if (st.hashEn[H_SMAC])
      hv = hv ^ fold({16'h0000, fSMac});
    if (st.hashEn[H_DMAC])
      hv = hv ^ fold({16'h0000, fDMac});
    if (st.hashEn[H_IP] && fIp4)
      hv = hv ^ fold({fSIp, fDIp});
    if (st.hashEn[H_L4] && fIp4 && fL4)
      hv = hv ^ fold({32'h0000_0000, fSL4, fDL4});
    grpOk = fDst < PW'(NGRP);
    gSel  = grpOk ? fDst[GW-1:0] : '0;
    cnt   = actCnt[gSel];
    pick  = (cnt == '0) ? '0 : HW'(hv % HW'(cnt));
    if (fIsGrp)
    begin
      egress = kth(act[gSel], pick[CW-1:0]);
      drop   = !grpOk || cnt == '0;
    end
    else
    begin
      egress = fDst;
      drop   = fDst >= PW'(NPORT);
    end
    rxSel = modeOf(st.mirMode, fSrc, M_RX);
    txSel = !drop && modeOf(st.mirMode, egress, M_TX);
  end

  assign fReady = !st.oValid || outReady;

  // APB decode and write checks
  mlps_dec_s             dec;
  logic [31:0]           rd;
  logic                  err;
  logic [NPORT-1:0]      others;
  logic [NPORT-1:0][1:0] wMode;
  logic [NPORT-1:0]      wMem;
  logic [PW-1:0]         wDst;
  logic                  wModeTx;

  always_comb
  begin
    dec     = mlps_decode(paddr);
    wMode   = pwdata[2*NPORT-1:0];
    wMem    = pwdata[NPORT-1:0];
    wDst    = pwdata[C_DST +: PW];
    wModeTx = 1'b0;
    others  = '0;
    for (int g = 0; g < NGRP; g++)
      if (GW'(g) != dec.idx)
        others = others | st.grpMem[g];
    for (int i = 0; i < NPORT; i++)
      if (wMode[i] != 2'h0 && inGrp[i])
        wModeTx = 1'b1;
    rd  = '0;
    err = 1'b0;
    unique case (dec.kind)
      R_CTRL:
      begin
        rd[C_EN]          = st.mirEn;
        rd[C_DST +: PW]   = st.mirDest;
        rd[C_HASH +: 4]   = st.hashEn;
        err = pwrite && pwdata[C_EN]
              && (wDst >= PW'(NPORT) || bitOf(inGrp, wDst)
                  || modeOf(st.mirMode, wDst, M_TX));
      end
      R_MIR:
      begin
        rd[2*NPORT-1:0] = st.mirMode;
        err = pwrite && (wModeTx
              || (st.mirEn && wMode[st.mirDest][M_TX]));
      end
      R_GRP:
      begin
        rd[NPORT-1:0]    = st.grpMem[dec.idx];
        rd[G_NEG]        = st.grpNeg[dec.idx];
        rd[G_SPD +: SPW] = st.grpSpd[dec.idx];
        err = pwrite && ((wMem & others) != '0
              || (wMem & mirSrc) != '0
              || (st.mirEn && wMem[st.mirDest]));
      end
      R_GST:
      begin
        rd[NPORT-1:0]   = act[dec.idx];
        rd[S_CNT +: CW] = actCnt[dec.idx];
        rd[S_UP]        = actCnt[dec.idx] != '0;
        err             = pwrite;
      end
      R_LINK:
      begin
        rd[L_UP +: NPORT]  = st.upS;
        rd[L_FDX +: NPORT] = st.fdS;
        err                = pwrite;
      end
      R_NONE:
        err = 1'b1;
    endcase
  end

  assign pready  = psel && penable && st.apbArm && ce;
  assign pslverr = pready && st.apbErr;
  assign prdata  = st.apbData;

  always_comb
  begin
    next_st     = st;
    next_st.upM = linkUp;
    next_st.upS = st.upM;
    next_st.fdM = fullDuplex;
    next_st.fdS = st.fdM;
    next_st.spM = portSpeed;
    next_st.spS = st.spM;
    if (psel && !penable)
    begin
      next_st.apbArm  = 1'b1;
      next_st.apbErr  = err;
      next_st.apbData = err ? 32'h0000_0000 : rd;
    end
    if (pready)
    begin
      next_st.apbArm = 1'b0;
      if (pwrite && !st.apbErr)
      begin
        unique case (dec.kind)
          R_CTRL:
          begin
            next_st.mirEn   = pwdata[C_EN];
            next_st.mirDest = wDst;
            next_st.hashEn  = pwdata[C_HASH +: 4];
          end
          R_MIR:
            next_st.mirMode = wMode;
          R_GRP:
          begin
            next_st.grpMem[dec.idx] = wMem;
            next_st.grpNeg[dec.idx] = pwdata[G_NEG];
            next_st.grpSpd[dec.idx] = pwdata[G_SPD +: SPW];
          end
          R_GST, R_LINK, R_NONE:
            next_st.apbArm = 1'b0;
        endcase
      end
    end
    if (st.oValid && outReady)
      next_st.oValid = 1'b0;
    if (fValid && fReady)
    begin
      next_st.oValid   = 1'b1;
      next_st.oPort    = egress;
      next_st.oDrop    = drop;
      next_st.oMir     = st.mirEn && (rxSel || txSel);
      next_st.oMirPort = st.mirDest;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st        <= '0;
      st.hashEn <= HASH_RST;
    end
    else if (ce)
      st <= next_st;
  end

  assign outValid   = st.oValid;
  assign outPort    = st.oPort;
  assign outDrop    = st.oDrop;
  assign outMirror  = st.oMir;
  assign outMirPort = st.oMirPort;
endmodule // mlps_top

// ---- tb/mlps_top_assertions.sv ----
`timescale 1ns/10ps
module mlps_top_assertions
  import mlps_pkg::*;
(
  input wire logic                  ref_clk,    // Clock
  input wire logic                  srst,       // Sync reset
  input wire logic                  ce,         // Clock enable
  input wire logic                  psel,       // APB select
  input wire logic                  penable,    // APB enable
  input wire logic                  pready,     // APB ready
  input wire logic                  inValid,    // Frame offered
  input wire logic                  inReady,    // Frame accepted
  input wire logic                  outValid,   // Decision valid
  input wire logic                  outReady,   // Decision taken
  input wire logic [mlps_pkg::PW-1:0] outPort,  // Egress port
  input wire logic                  outDrop,    // No egress
  input wire logic                  outMirror,  // Make a copy
  input wire logic [mlps_pkg::PW-1:0] outMirPort // Copy port
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  chk_out_hold: assert property (
    outValid && !outReady |=> outValid && $stable(outPort)
      && $stable(outDrop) && $stable(outMirror) && $stable(outMirPort))
    else $error("decision changed while stalled");
  chk_apb_answer: assert property (
    (psel && !penable && ce ##1 psel && penable && ce) |-> pready)
    else $error("no ready in first access cycle");
  chk_apb_idle: assert property (
    pready |-> psel && penable && ce)
    else $error("ready outside an access cycle");
  chk_take_out: assert property (
    $rose(outValid) |-> $past(inValid && inReady && ce, 2))
    else $error("decision without a descriptor two edges before");
  chk_no_ghost: assert property (
    !outValid && !inValid && !$past(inValid) |=> !outValid)
    else $error("decision appeared from nothing");
  chk_port_range: assert property (
    outValid && !outDrop |-> outPort < 4'(NPORT))
    else $error("egress port out of range");
  chk_mir_range: assert property (
    outValid && outMirror |-> outMirPort < 4'(NPORT))
    else $error("mirror port out of range");
  chk_reset_out: assert property (
    $fell(srst) |-> !outValid && !outMirror && inReady && !pready)
    else $error("outputs not idle after reset");

  cov_mirror: cover property (outValid && outReady && outMirror);
  cov_drop: cover property (outValid && outReady && outDrop);
  cov_full: cover property (inValid && !inReady);
endmodule // mlps_top_assertions

bind mlps_top mlps_top_assertions i_mlps_top_assertions (
  .ref_clk(ref_clk), .srst(srst), .ce(ce), .psel(psel),
  .penable(penable), .pready(pready), .inValid(inValid),
  .inReady(inReady), .outValid(outValid), .outReady(outReady),
  .outPort(outPort), .outDrop(outDrop), .outMirror(outMirror),
  .outMirPort(outMirPort)
);

// ---- tb/mlps_port_model.sv ----
`timescale 1ns/10ps
module mlps_port_model (
  input  wire logic ref_clk,  // Clock
  input  wire logic srst,     // Sync reset
  input  wire logic stall,    // Hold egress off
  output logic      outReady  // Decision taken
);
  // Egress port busy about one cycle in four
  always @(posedge ref_clk)
    outReady <= !srst && !stall && ($urandom() % 4 != 0);
endmodule // mlps_port_model

// ---- tb/mlps_top_test.sv ----
`timescale 1ns/10ps
module mlps_top_test;
  import mlps_pkg::*;
  logic                      ref_clk = 0, srst = 1, ce = 1, stall = 0;
  logic                      psel = 0, penable = 0, pwrite = 0;
  logic [7:0]                paddr = '0;
  logic [31:0]               pwdata = '0, prdata;
  logic                      pready, pslverr, inReady, outValid;
  logic                      outReady, outDrop, outMirror, sawFull = 0;
  logic [NPORT-1:0]          linkUp = '1, fullDuplex = '1;
  logic [NPORT-1:0][SPW-1:0] portSpeed = 20'h0_4000;
  logic                      inValid = 0, inDstIsGrp = 0;
  logic                      inIsIpv4 = 1, inIsL4 = 1;
  logic [PW-1:0]             inSrcPort = '0, inDstId = '0;
  logic [PW-1:0]             outPort, outMirPort;
  logic [MACW-1:0]           inSrcMac = '0, inDstMac = '0, fMac = '0;
  logic [IPW-1:0]            inSrcIp = '0, inDstIp = '0, fSip = '0, fDip = '0;
  logic [L4W-1:0]            inSrcL4 = '0, inDstL4 = '0, fSl4 = '0, fDl4 = '0;
  logic [1:0]                mode [16] = '{default: 2'h0};
  logic [9:0]                expQ [$];
  int                        bad_count = 0, num_checks = 0;

  mlps_top i_mlps_top (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .linkUp(linkUp), .fullDuplex(fullDuplex), .portSpeed(portSpeed),
    .inValid(inValid), .inReady(inReady), .inSrcPort(inSrcPort),
    .inDstIsGrp(inDstIsGrp), .inDstId(inDstId), .inSrcMac(inSrcMac),
    .inDstMac(inDstMac), .inSrcIp(inSrcIp), .inDstIp(inDstIp),
    .inSrcL4(inSrcL4), .inDstL4(inDstL4), .inIsIpv4(inIsIpv4),
    .inIsL4(inIsL4), .outValid(outValid), .outReady(outReady),
    .outPort(outPort), .outDrop(outDrop), .outMirror(outMirror),
    .outMirPort(outMirPort));
  mlps_port_model i_mlps_port_model (.ref_clk(ref_clk), .srst(srst),
    .stall(stall), .outReady(outReady));

  initial
    forever #12.5 ref_clk = ~ref_clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic limit(int n, int lim);
    if (n >= lim)
    begin
      check("handshake wait", 0, n);
      wrap_up();
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic e,
                     logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    limit(n, 50);
    check("pslverr", e, pslverr);
    if (!w)
      check("prdata", r, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic send(logic [3:0] s, logic g, logic [3:0] d, logic [9:0] e);
    int n;
    n = 0;
    inValid <= 1'b1;
    inSrcPort <= s;
    inDstIsGrp <= g;
    inDstId <= d;
    inSrcMac <= fMac;
    inDstMac <= MACW'({$urandom(), $urandom()});
    inSrcIp <= fSip;
    inDstIp <= fDip;
    inSrcL4 <= fSl4;
    inDstL4 <= fDl4;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (inReady === 1'b0)
        sawFull = 1'b1;
    end
    while ((inReady !== 1'b1 || ce !== 1'b1) && n < 200);
    limit(n, 200);
    expQ.push_back(e);
  endtask

  task automatic drain();
    int n;
    n = 0;
    inValid <= 1'b0;
    while (expQ.size() != 0 && n < 500)
    begin
      @(posedge ref_clk);
      n++;
    end
    limit(n, 500);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic newFlow();
    fMac = MACW'({$urandom(), $urandom()});
    fSip = $urandom();
    fDip = $urandom();
    fSl4 = L4W'($urandom());
    fDl4 = L4W'($urandom());
  endtask

  function automatic logic [7:0] fold(logic [63:0] v);
    logic [7:0] h;
    h = '0;
    for (int i = 0; i < 8; i++)
      h ^= v[8*i +: 8];
    return h;
  endfunction

  // Port destination: Rx copy even when dropped, Tx copy only if sent
  task automatic pframe(logic [3:0] s, logic [3:0] d, logic en);
    logic drop;
    logic mir;
    drop = d >= NPORT;
    mir = en && (mode[s][0] || (!drop && mode[d][1]));
    send(s, 1'b0, d, {drop ? 4'h0 : d, drop, mir, mir ? 4'h9 : 4'h0});
  endtask

  // Group 0 active members are 5 and 6, or 6 alone
  task automatic gframe(logic [3:0] g, int cnt);
    logic [7:0] h;
    logic [3:0] p;
    h = fold({16'h0, fMac}) ^ fold({fSip, fDip}) ^ fold({32'h0, fSl4, fDl4});
    p = (cnt == 1 || h[0]) ? 4'd6 : 4'd5;
    send(4'd0, 1'b1, g, g >= NGRP ? 10'b00_0010_0000 : {p, 6'h00});
  endtask

  always @(negedge ref_clk)
    if (outValid === 1'b1 && outReady === 1'b1 && ce === 1'b1)
    begin
      if (expQ.size() == 0)
        check("spare decision", 0, 1);
      else
        check("decision", expQ.pop_front(), {outDrop ? 4'h0 : outPort,
          outDrop, outMirror, outMirror ? outMirPort : 4'h0});
    end

  initial
  begin
    void'($urandom(32'hb534c169));
    newFlow();
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    apb(0, A_CTRL, 0, 0, 32'h0000_0d00);
    apb(0, A_MIR, 0, 0, 32'h0000_0000);
    apb(0, 8'h3c, 0, 1, 32'h0000_0000);
    apb(1, A_MIR, 32'h0000_00e4, 0, 0);
    mode[1] = 2'h1;
    mode[2] = 2'h2;
    mode[3] = 2'h3;
    for (int i = 0; i < 8; i++)
      pframe(4'(i % 4), 4'(3 - i % 4), 1'b0);
    drain();
    apb(1, A_CTRL, 32'h0000_0d91, 0, 0);
    apb(1, A_MIR, 32'h0008_00e4, 1, 0);
    apb(0, A_MIR, 0, 0, 32'h0000_00e4);
    for (int i = 0; i < 24; i++)
      pframe(4'($urandom_range(0, 4)), (i % 6 == 5) ? 4'd12 :
             4'($urandom_range(0, 4)), 1'b1);
    drain();
    apb(1, A_GRP, 32'h0000_00e0, 0, 0);
    apb(0, A_GST, 0, 0, 32'h0012_0060);
    apb(1, A_GRP + 8'h04, 32'h0000_0040, 1, 0);
    apb(1, A_MIR, 32'h0000_04e4, 1, 0);
    for (int i = 0; i < 8; i++)
    begin
      if (i % 2 == 0)
        newFlow();
      gframe(4'd0, 2);
    end
    gframe(4'd5, 2);
    drain();
    stall <= 1'b1;
    fork
      begin
        repeat (10) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (5) @(posedge ref_clk);
        ce <= 1'b1;
        repeat (25) @(posedge ref_clk);
        stall <= 1'b0;
      end
    join_none
    for (int i = 0; i < 20; i++)
      pframe(4'd3, 4'd1, 1'b1);
    check("input refused when full", 1, sawFull);
    drain();
    linkUp[5] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    apb(0, A_GST, 0, 0, 32'h0011_0040);
    gframe(4'd0, 1);
    gframe(4'd0, 1);
    drain();
    linkUp[5] <= 1'b1;
    apb(1, A_CTRL, 32'h0000_0d00, 0, 0);
    apb(1, A_MIR, 32'h0000_0000, 0, 0);
    apb(1, A_GRP, 32'h0001_03ff, 0, 0);
    apb(0, A_GST, 0, 0, 32'h0018_017f);
    wrap_up();
  end
endmodule // mlps_top_test
